// ===== ext_irq_pkg.sv
package ext_irq_pkg;
   localparam int          NUM_IRQ         = 8;
   localparam int          NUM_KEY         = 16;
   localparam int          NUM_WAKE        = 8;
   localparam int          NUM_PERIPH      = 2;
   localparam int          NUM_CAND        = NUM_IRQ + NUM_PERIPH;
   localparam int          NUM_PINS        = 1 + NUM_IRQ + NUM_KEY + NUM_WAKE;
   localparam int          ADDR_W          = 24;
   // Sense selection codes per request pin
   localparam logic [1:0]  SENSE_LOW       = 2'h0;
   localparam logic [1:0]  SENSE_FALL      = 2'h1;
   localparam logic [1:0]  SENSE_RISE      = 2'h2;
   localparam logic [1:0]  SENSE_BOTH      = 2'h3;
   // Reset values
   localparam logic [7:0]  FLAGS_RESET     = 8'h00;
   localparam logic [NUM_PINS-1:0] PINS_IDLE = {NUM_PINS{1'b1}};
   // Vector numbers
   localparam logic [7:0]  NMI_VECTOR      = 8'h07;
   localparam logic [7:0]  IRQ_VECTOR_BASE = 8'h10;
   localparam logic [7:0]  PERIPH_VECTOR0  = 8'h19;
   // Requests able to leave software standby: 7, 6, 2, 1, 0
   localparam logic [7:0]  WAKE_CAPABLE    = 8'hC7;
   // Request to the CPU core
   typedef struct packed {
      logic              valid;
      logic              nmi;
      logic [7:0]        vector;
      logic [ADDR_W-1:0] address;
   } cpu_request_t;
   // Level-control bit (index into level_control[7:3]) for each request
   function automatic logic [2:0] irq_level_bit(input int i);
      case (i)
         0:       irq_level_bit = 3'h7;
         1:       irq_level_bit = 3'h6;
         2, 3:    irq_level_bit = 3'h5;
         4, 5:    irq_level_bit = 3'h4;
         default: irq_level_bit = 3'h3;
      endcase
   endfunction
   // Vector number of candidate i: requests first, then peripherals
   function automatic logic [7:0] cand_vector(input int i);
      if (i < NUM_IRQ) cand_vector = IRQ_VECTOR_BASE + 8'(i);
      else cand_vector = PERIPH_VECTOR0 + 8'(i - NUM_IRQ);
   endfunction
endpackage

// ===== ext_irq_source.sv
// Contract
// R1 - Wake and high keys feed request 7; low keys request 6
// R2 - Only NMI, requests 7,6,2,1,0 wake standby
// R3 - NMI wins always, ignores masks
// R4 - One bit picks NMI rising or falling edge
// R5 - Each external request has its own vector
// R6 - Two-bit sense: low, falling, rising, both
// R7 - Codes 01 fall, 10 rise, 11 both, 00 low
// R8 - Request forwarded only when its enable set
// R9 - Enable 1 passes; enables reset to 0
// R10 - Each request has software-clearable status flag
// R11 - Flag clears on write 0 after read 1
// R12 - Flag clears on handling; low mode needs high
// R13 - Flag sets on condition even when disabled
// R14 - Detection ignores port direction setting
// R15 - Software keeps direction bit while pin used
// R16 - Software clears key mask 6 for request 6
// R17 - Any high-key or wake mask 0 ignores pin 7
// R18 - Key or wake input active when mask 0
// R19 - Shared requests use low or falling sense
// R20 - Peripheral request forwarded only when enabled
// R21 - Lower vector wins; fixed order within level
// R22 - Level 1 requests served before level 0
// R23 - Level bits 7,6,5,4,3 map requests 0..7
// R24 - Vectors 7 for NMI, 16..23 for requests
// R25 - Address is vector times 2 or 4
// R26 - All pins pass two-flop synchroniser first
// R27 - Unmasked active-low inputs combine into one level
module ext_irq_source
   import ext_irq_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rstn,
   input  wire logic                  nmi_pin,
   input  wire logic [NUM_IRQ-1:0]    ext_request_n,
   input  wire logic [NUM_KEY-1:0]    key_sense_input,
   input  wire logic [NUM_WAKE-1:0]   wake_event_input,
   input  wire logic                  nmi_edge_select,
   input  wire logic [15:0]           sense_select,
   input  wire logic [7:0]            request_enable,
   input  wire logic [7:0]            key_mask_low,
   input  wire logic [7:0]            key_mask_high,
   input  wire logic [7:0]            wake_mask,
   input  wire logic [7:3]            level_control,
   input  wire logic                  cpu_int_mask,
   input  wire logic                  user_mask_bit,
   input  wire logic                  advanced_mode,
   input  wire logic                  standby,
   input  wire logic                  flag_read,
   input  wire logic                  flag_write,
   input  wire logic [7:0]            flag_write_data,
   input  wire logic                  ack_valid,
   input  wire logic [7:0]            ack_vector,
   input  wire logic [NUM_PERIPH-1:0] periph_flag,
   input  wire logic [NUM_PERIPH-1:0] periph_enable,
   input  wire logic [NUM_PERIPH-1:0] periph_level,
   output logic      [7:0]            request_flags,
   output cpu_request_t               cpu_request,
   output logic                       wake_request
);
   logic                rst_meta_reg;
   logic                rst_sync_reg;
   logic [NUM_PINS-1:0] sync1_reg;
   logic [NUM_PINS-1:0] sync2_reg;
   logic [NUM_IRQ-1:0]  src_prev_reg;
   logic                nmi_prev_reg;
   logic                nmi_pending_reg;
   logic [7:0]          flags_reg;
   logic [7:0]          flags_next;
   logic [7:0]          armed_reg;
   cpu_request_t        cpu_request_reg;
   cpu_request_t        cpu_request_next;
   logic                wake_request_reg;

   // Reset release through two flops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // Two-flop synchroniser on every pin, direction of the port not involved
   always_ff @(posedge clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         sync1_reg <= PINS_IDLE;
         sync2_reg <= PINS_IDLE;
      end else begin
         sync1_reg <= {nmi_pin, ext_request_n, key_sense_input, wake_event_input}; // [R26] [R14]
         sync2_reg <= sync1_reg; // [R26]
      end
   end

   // Synchronised pin groups
   wire                nmi_s  = sync2_reg[NUM_PINS-1];
   wire [NUM_IRQ-1:0]  ext_s  = sync2_reg[NUM_PINS-2 -: NUM_IRQ];
   wire [NUM_KEY-1:0]  key_s  = sync2_reg[NUM_WAKE +: NUM_KEY];
   wire [NUM_WAKE-1:0] wake_s = sync2_reg[NUM_WAKE-1:0];

   // Shared sources: unmasked active-low inputs ANDed into one level
   wire key_low_n   = &(key_s[7:0] | key_mask_low); // [R18] [R27]
   wire key_high_n  = &(key_s[15:8] | key_mask_high); // [R18] [R27]
   wire wake_n      = &(wake_s | wake_mask); // [R18] [R27]
   wire pin6_n      = ext_s[6] | key_mask_low[6]; // [R16]
   wire irq7_pin_en = (&key_mask_high) & (&wake_mask);
   wire pin7_n      = ext_s[7] | ~irq7_pin_en; // [R17]
   wire [NUM_IRQ-1:0] src_n = {pin7_n & key_high_n & wake_n, pin6_n & key_low_n,
                               ext_s[5:0]}; // [R1]

   // Sense condition per request source
   logic [NUM_IRQ-1:0] flag_set;
   always_comb begin
      for (int i = 0; i < NUM_IRQ; i++) begin
         case (sense_select[2*i +: 2])
            SENSE_FALL: flag_set[i] = src_prev_reg[i] & ~src_n[i]; // [R6] [R7]
            SENSE_RISE: flag_set[i] = ~src_prev_reg[i] & src_n[i]; // [R6] [R7]
            SENSE_BOTH: flag_set[i] = src_prev_reg[i] ^ src_n[i]; // [R6] [R7]
            default:    flag_set[i] = ~src_n[i]; // [R6] [R7]
         endcase
      end
   end

   // Flag clearing by software and by exception handling
   logic [NUM_IRQ-1:0] ack_clear;
   always_comb begin
      for (int i = 0; i < NUM_IRQ; i++) begin
         ack_clear[i] = ack_valid && ack_vector == cand_vector(i) &&
                        (sense_select[2*i +: 2] != SENSE_LOW || src_n[i]); // [R12] [R5]
      end
   end
   wire [7:0] sw_clear = {8{flag_write}} & ~flag_write_data & armed_reg; // [R11]
   assign flags_next = (flags_reg & ~(sw_clear | ack_clear)) | flag_set; // [R13] [R10]

   // NMI edge detection
   wire nmi_edge  = nmi_edge_select ? (~nmi_prev_reg & nmi_s) : (nmi_prev_reg & ~nmi_s); // [R4]
   wire nmi_clear = ack_valid && ack_vector == NMI_VECTOR;

   // Edge history and flag state
   always_ff @(posedge clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         src_prev_reg    <= {NUM_IRQ{1'b1}};
         nmi_prev_reg    <= 1'b1;
         nmi_pending_reg <= 1'b0;
         flags_reg       <= FLAGS_RESET;
         armed_reg       <= FLAGS_RESET;
      end else begin
         src_prev_reg    <= src_n;
         nmi_prev_reg    <= nmi_s;
         nmi_pending_reg <= nmi_edge | (nmi_pending_reg & ~nmi_clear);
         flags_reg       <= flags_next;
         armed_reg       <= flag_read ? flags_reg : (armed_reg & flags_next); // [R11]
      end
   end

   // Forwarded requests and their control levels
   wire [NUM_IRQ-1:0]    irq_fwd    = flags_reg & request_enable; // [R8] [R9]
   wire [NUM_PERIPH-1:0] periph_fwd = periph_flag & periph_enable; // [R20]
   wire [NUM_CAND-1:0]   cand       = {periph_fwd, irq_fwd};
   logic [NUM_CAND-1:0]  cand_level;
   always_comb begin
      for (int i = 0; i < NUM_CAND; i++) begin
         if (i < NUM_IRQ) cand_level[i] = level_control[irq_level_bit(i)]; // [R23]
         else cand_level[i] = periph_level[i - NUM_IRQ];
      end
   end
   wire [NUM_CAND-1:0] hi_req = cand & cand_level & {NUM_CAND{~cpu_int_mask}}; // [R22]
   wire [NUM_CAND-1:0] lo_req = cand & ~cand_level &
                                {NUM_CAND{~cpu_int_mask & ~user_mask_bit}}; // [R22]

   // Priority selection: NMI, then level 1, then level 0, lowest vector first
   logic [7:0] sel_vector;
   logic       sel_valid;
   always_comb begin
      sel_vector = 8'h00;
      sel_valid  = 1'b0;
      for (int i = NUM_CAND - 1; i >= 0; i--) begin
         if (lo_req[i]) begin
            sel_vector = cand_vector(i); // [R21] [R24]
            sel_valid  = 1'b1;
         end
      end
      for (int i = NUM_CAND - 1; i >= 0; i--) begin
         if (hi_req[i]) begin
            sel_vector = cand_vector(i); // [R21] [R22]
            sel_valid  = 1'b1;
         end
      end
      if (nmi_pending_reg) begin
         sel_vector = NMI_VECTOR; // [R3] [R24]
         sel_valid  = 1'b1;
      end
   end

   // Vector address for the selected source
   always_comb begin
      cpu_request_next.valid   = sel_valid;
      cpu_request_next.nmi     = nmi_pending_reg;
      cpu_request_next.vector  = sel_vector;
      cpu_request_next.address = advanced_mode ? {14'h0000, sel_vector, 2'h0}
                                               : {15'h0000, sel_vector, 1'h0}; // [R25]
   end

   // Registered outputs
   always_ff @(posedge clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         cpu_request_reg  <= '0;
         wake_request_reg <= 1'b0;
      end else begin
         cpu_request_reg  <= cpu_request_next;
         wake_request_reg <= standby &
                             (nmi_pending_reg | (|(irq_fwd & WAKE_CAPABLE))); // [R2]
      end
   end

   assign request_flags = flags_reg;
   assign cpu_request   = cpu_request_reg;
   assign wake_request  = wake_request_reg;

   // Checks on the design's own behaviour
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_sync_reg);

   a_nmi_top_priority: assert property (nmi_pending_reg |=>
      cpu_request.valid && cpu_request.vector == NMI_VECTOR) // [R3]
      else $error("NMI pending but not presented first");
   a_nmi_edge_select: assert property (nmi_edge |=> nmi_pending_reg) // [R4]
      else $error("NMI edge did not raise pending");
   a_flag_set_wins: assert property (flag_set[0] |=> request_flags[0]) // [R13]
      else $error("Flag 0 not set by its sense condition");
   a_fall_sense: assert property (sense_select[1:0] == SENSE_FALL && $past(src_n[0])
      && !src_n[0] |=> request_flags[0]) // [R7]
      else $error("Falling edge on source 0 not flagged");
   a_write_one_noop: assert property (flag_write && &flag_write_data && !ack_valid
      |=> (request_flags & $past(flags_reg)) == $past(flags_reg)) // [R11]
      else $error("Writing ones cleared a flag");
   a_clear_cause: assert property ($fell(request_flags[0]) |->
      $past(sw_clear[0] || ack_clear[0])) // [R11]
      else $error("Flag 0 cleared without cause");
   a_enable_gates: assert property (cpu_request.valid && !cpu_request.nmi &&
      cpu_request.vector < PERIPH_VECTOR0 |-> $past(|irq_fwd)) // [R8]
      else $error("Request presented without enabled flag");
   a_wake_sources: assert property (wake_request |->
      $past(nmi_pending_reg || |(flags_reg & request_enable & WAKE_CAPABLE))) // [R2]
      else $error("Wake from a source not allowed");
   a_irq7_ignored: assert property (!irq7_pin_en && key_high_n && wake_n |-> src_n[7]) // [R17]
      else $error("Request 7 pin passed while masked");
   a_vector_address: assert property (cpu_request.valid |-> cpu_request.address ==
      ($past(advanced_mode) ? {14'h0000, cpu_request.vector, 2'h0}
                            : {15'h0000, cpu_request.vector, 1'h0})) // [R25]
      else $error("Vector address does not match vector");

   // Mask bits: I blocks every maskable source, UI blocks level 0 only
   a_mask_blocks_all: assert property (cpu_request.valid && !cpu_request.nmi |->
      !$past(cpu_int_mask)) // [R22]
      else $error("Maskable request presented while I set");
   a_ui_level_zero: assert property (user_mask_bit && !nmi_pending_reg && hi_req == '0
      |=> !cpu_request.valid) // [R22]
      else $error("Level 0 request passed while UI set");
   a_level_first: assert property (hi_req[3] && !nmi_pending_reg && hi_req[2:0] == 3'h0
      |=> cpu_request.vector == IRQ_VECTOR_BASE + 8'h03) // [R22]
      else $error("Level 1 request 3 not presented first");

   // Flag behaviour under low-level sensing and software clearing
   a_low_level_hold: assert property (sense_select[1:0] == SENSE_LOW && !src_n[0]
      |=> request_flags[0]) // [R12]
      else $error("Low level on source 0 did not hold flag");
   a_sw_clear_bit0: assert property (sw_clear[0] && !flag_set[0]
      |=> !request_flags[0]) // [R11]
      else $error("Armed write of zero did not clear flag 0");
   a_unarmed_keeps: assert property (flags_reg[0] && !armed_reg[0] && !ack_clear[0]
      |=> request_flags[0]) // [R11]
      else $error("Flag 0 cleared without being read first");

   // Exception handling takes the pending NMI away unless a new edge arrives
   a_ack_clears_nmi: assert property (nmi_clear && !nmi_edge
      |=> !nmi_pending_reg) // [R3]
      else $error("NMI pending survived its acknowledge");

   // Forwarding only through enable bits
   a_periph_gate: assert property (cpu_request.valid && cpu_request.vector >= PERIPH_VECTOR0
      |-> $past(|periph_fwd)) // [R20]
      else $error("Peripheral request presented while disabled");
   a_enable_off: assert property (request_enable == 8'h00 && periph_fwd == '0 &&
      !nmi_pending_reg |=> !cpu_request.valid) // [R8]
      else $error("Request presented with all enables clear");

   // Standby exit only from allowed sources
   a_wake_blocked: assert property (standby && !nmi_pending_reg &&
      (irq_fwd & WAKE_CAPABLE) == 8'h00 |=> !wake_request) // [R2]
      else $error("Wake raised by a source not allowed");

   // Key mask bit 6 also shuts the request 6 pin
   a_pin6_masked: assert property (key_mask_low[6] && key_low_n |-> src_n[6]) // [R16]
      else $error("Request 6 pin passed while masked");
endmodule

// ===== cpu_model.sv
module cpu_model
   import ext_irq_pkg::*;
#(
   parameter int DELAY = 2
)
(
   input  wire logic         clk,
   input  wire logic         ack_on,
   input  wire cpu_request_t cpu_request,
   output logic              ack_valid,
   output logic [7:0]        ack_vector
);
   timeunit 1ns;
   timeprecision 1ns;
   int wait_cnt = 0;
   initial {ack_valid, ack_vector} = 9'h000;
   // Takes the shown request after DELAY cycles; vector bus toggles when idle
   always @(negedge clk) begin
      ack_valid  <= 1'b0;
      ack_vector <= ~ack_vector;
      if (!(ack_on && cpu_request.valid)) begin
         wait_cnt <= 0;
      end else if (wait_cnt == DELAY) begin
         ack_valid  <= 1'b1;
         ack_vector <= cpu_request.vector;
         wait_cnt   <= 0;
      end else begin
         wait_cnt <= wait_cnt + 1;
      end
   end
endmodule

// ===== test_ext_irq_source.sv
module test_ext_irq_source
   import ext_irq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rstn = 0, nmi_pin = 1, nmi_edge_select = 0, cpu_int_mask = 0;
   logic user_mask_bit = 0, advanced_mode = 0, standby = 0, ack_on = 0;
   logic flag_read = 0, flag_write = 0, ack_valid, wake_request;
   logic [7:0] ext_request_n = 8'hFF, wake_event_input = 8'hFF, wake_mask = 8'hFF;
   logic [7:0] request_enable = 8'h00, key_mask_low = 8'hBF, key_mask_high = 8'hFF;
   logic [7:0] flag_write_data = 8'h00, ack_vector, request_flags;
   logic [15:0] key_sense_input = 16'hFFFF, sense_select = 16'h0000;
   logic [7:3] level_control = 5'h00;
   logic [1:0] periph_flag = 2'h0, periph_enable = 2'h0, periph_level = 2'h0;
   cpu_request_t cpu_request;
   int err_total = 0, tests_run = 0;

   ext_irq_source i_ext_irq_source (.*);
   cpu_model i_cpu_model (.clk(clk), .ack_on(ack_on), .cpu_request(cpu_request),
      .ack_valid(ack_valid), .ack_vector(ack_vector));

   // Clock and watchdog
   initial begin
      forever #25 clk = ~clk;
   end
   initial begin
      #(3000 * 50);
      err_total++;
      report_and_stop();
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic check(input logic [39:0] seen, input logic [39:0] expected);
      tests_run++;
      if (seen !== expected) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, expected);
      end
   endtask

   // Optional read that arms the flags, then a write of d
   task automatic flag_clear(input logic rd, input logic [7:0] d);
      flag_read = rd;
      cyc(1);
      flag_read = 1'b0;
      flag_write = 1'b1;
      flag_write_data = d;
      cyc(1);
      flag_write = 1'b0;
      cyc(2);
   endtask

   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      cyc(8);
      rstn = 1'b1;
      cyc(4);
      check(request_flags, 8'h00);
      check({cpu_request, wake_request}, 35'h0);
      // Falling edge on request 0 while disabled, then enabled
      sense_select = 16'h0001;
      ext_request_n[0] = 1'b0;
      cyc(5);
      check(request_flags, 8'h01);
      check(cpu_request.valid, 1'b0);
      request_enable = 8'h01;
      cyc(2);
      check({cpu_request.valid, cpu_request.vector}, 9'h110);
      check(cpu_request.address, 24'h000020);
      advanced_mode = 1'b1;
      cyc(2);
      check(cpu_request.address, 24'h000040);
      advanced_mode = 1'b0;
      ext_request_n[0] = 1'b1;
      flag_clear(1'b0, 8'h00);
      check(request_flags, 8'h01);
      flag_clear(1'b1, 8'hFF);
      check(request_flags, 8'h01);
      flag_clear(1'b1, 8'h00);
      check({request_flags, cpu_request.valid}, 9'h000);
      // Falling, rising and both-edge codes on request 1
      for (int c = 1; c < 4; c++) begin
         sense_select = 16'(c) << 2;
         ext_request_n[1] = 1'b0;
         cyc(5);
         check(request_flags[1], 1'(c != 2));
         flag_clear(1'b1, 8'h00);
         ext_request_n[1] = 1'b1;
         cyc(5);
         check(request_flags[1], 1'(c != 1));
         flag_clear(1'b1, 8'h00);
      end
      // Low level keeps the flag set while the pin stays low
      sense_select = 16'h0000;
      ext_request_n[4] = 1'b0;
      cyc(5);
      flag_clear(1'b1, 8'h00);
      check(request_flags, 8'h10);
      ext_request_n[4] = 1'b1;
      cyc(4);
      flag_clear(1'b1, 8'h00);
      check(request_flags, 8'h00);
      // Default order, then level 1 for requests 2-3, then CPU mask
      sense_select = 16'h0041;
      request_enable = 8'h09;
      ext_request_n = 8'hF6;
      cyc(6);
      check(cpu_request.vector, 8'h10);
      level_control = 5'b00100;
      cyc(2);
      check(cpu_request.vector, 8'h13);
      user_mask_bit = 1'b1;
      level_control = 5'h00;
      cyc(2);
      check(cpu_request.valid, 1'b0);
      level_control = 5'b00100;
      cyc(2);
      check({cpu_request.valid, cpu_request.vector}, 9'h113);
      user_mask_bit = 1'b0;
      cpu_int_mask = 1'b1;
      cyc(2);
      check(cpu_request.valid, 1'b0);
      // Falling-edge NMI gets through the mask
      nmi_pin = 1'b0;
      cyc(6);
      check({cpu_request.valid, cpu_request.nmi, cpu_request.vector}, 10'h307);
      ack_on = 1'b1;
      cyc(8);
      check(cpu_request.valid, 1'b0);
      cpu_int_mask = 1'b0;
      cyc(20);
      check({request_flags, cpu_request.valid}, 9'h000);
      ack_on = 1'b0;
      level_control = 5'h00;
      ext_request_n = 8'hFF;
      // Rising-edge NMI
      nmi_edge_select = 1'b1;
      cyc(5);
      check(cpu_request.valid, 1'b0);
      nmi_pin = 1'b1;
      cyc(6);
      check({cpu_request.valid, cpu_request.nmi, cpu_request.vector}, 10'h307);
      ack_on = 1'b1;
      cyc(8);
      ack_on = 1'b0;
      // Key and wake inputs on the shared requests, falling sense only
      sense_select = 16'h5000;
      request_enable = 8'h00;
      key_mask_low = 8'hBE;
      key_sense_input = 16'hFFFD;
      cyc(5);
      check(request_flags, 8'h00);
      key_sense_input = 16'hFFFC;
      cyc(5);
      check(request_flags, 8'h40);
      key_sense_input = 16'hFFFF;
      flag_clear(1'b1, 8'h00);
      wake_mask = 8'hFE;
      ext_request_n[7] = 1'b0;
      cyc(5);
      check(request_flags, 8'h00);
      wake_event_input = 8'hFE;
      cyc(5);
      check(request_flags, 8'h80);
      {ext_request_n, wake_event_input, wake_mask} = 24'hFFFFFF;
      cyc(4);
      flag_clear(1'b1, 8'h00);
      // Peripheral source passes only when enabled
      periph_flag = 2'h1;
      cyc(3);
      check(cpu_request.valid, 1'b0);
      periph_enable = 2'h1;
      cyc(3);
      check({cpu_request.valid, cpu_request.vector}, 9'h119);
      periph_flag = 2'h0;
      // Standby exit by request 2 but not by request 3
      standby = 1'b1;
      sense_select = 16'h0050;
      request_enable = 8'h0C;
      ext_request_n = 8'hF7;
      cyc(6);
      check(wake_request, 1'b0);
      ext_request_n = 8'hF3;
      cyc(6);
      check(wake_request, 1'b1);
      report_and_stop();
   end
endmodule
